/* hdl/sbt_pin_sync.sv */
// Two-stage synchroniser and edge finder for the scan port pins
`timescale 1ns/1ps
module sbt_pin_sync
   import sbt_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rst,
   input  wire sbt_pins_t pins_in,
   output sbt_pins_t      pins_out,
   output logic           tck_rise,
   output logic           tck_fall
);

   // All state in one struct
   typedef struct packed {
      sbt_pins_t s1;    // First stage, read only by s2
      sbt_pins_t s2;    // Second stage
      logic      tck_d; // Delayed clock level for edges
   } sbt_sync_state_t;

   sbt_sync_state_t st_r;
   sbt_sync_state_t st_nxt;

   // Next-state fill
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.s1    = pins_in;
      st_nxt.s2    = st_r.s1;
      st_nxt.tck_d = st_r.s2.tck;
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Edge strobes from the second stage only
   assign pins_out = st_r.s2;
   assign tck_rise = st_r.s2.tck & ~st_r.tck_d;
   assign tck_fall = ~st_r.s2.tck & st_r.tck_d;

endmodule // sbt_pin_sync

/* hdl/sbt_scan_tap.sv */
// Scan test access port of the burst SRAM
`timescale 1ns/1ps
module sbt_scan_tap
   import sbt_pkg::*;
#(
   parameter bit DEPTH_1M = 1'b1,  // Deep configuration when set
   parameter bit WIDTH_18 = 1'b1   // Narrow configuration when set
)
(
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                tck,
   input  wire logic                tms,
   input  wire logic                tdi,
   input  wire logic [RING_LEN-1:0] ring_in,
   output logic                     tdo,
   output logic                     tdo_oe,
   output logic                     sram_out_off,
   output logic [IR_LEN-1:0]        ir_active,
   output sbt_state_t               tap_state
);

   // Fixed identity word assembled from fields
   localparam logic [ID_LEN-1:0] ID_VALUE = {
      ID_REVISION,
      DEPTH_1M ? ID_DEPTH_1M : ID_DEPTH_512,
      WIDTH_18 ? ID_WIDTH_18 : ID_WIDTH_36,
      ID_DEVICE,
      ID_MAKER,
      ID_PRESENT};

   // Whole module state except the tms_cnt_r counter
   typedef struct packed {
      sbt_state_t          fsm;      // Controller state
      logic [IR_LEN-1:0]   ir_sh;    // Instruction shift stage
      logic [IR_LEN-1:0]   ir;       // Active instruction
      logic                byp;      // Bypass register
      logic [ID_LEN-1:0]   id_sh;    // Identity shift register
      logic [RING_LEN-1:0] ring;     // Pin ring register
      logic                tdo;      // Serial output
      logic                tdo_oe;   // Serial output enable
      logic                out_off;  // SRAM outputs forced off
   } sbt_tap_state_t;

   sbt_tap_state_t st_r;
   sbt_tap_state_t st_nxt;
   sbt_pins_t      pins;       // Synchronised pins
   logic           tck_rise;   // Test clock rising strobe
   logic           tck_fall;   // Test clock falling strobe

   // Pin synchroniser
   sbt_pin_sync u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .pins_in  ('{tck: tck, tms: tms, tdi: tdi}),
      .pins_out (pins),
      .tck_rise (tck_rise),
      .tck_fall (tck_fall)
   );

   // True when the instruction routes the ring register
   function automatic logic sel_ring(logic [IR_LEN-1:0] i);
      return (i == INS_EXT_CAPTURE) || (i == INS_SAMPLE_Z) ||
             (i == INS_SAMPLE);
   endfunction

   // Next-state logic, rising edges sample and falling edges drive
   always_comb
   begin
      st_nxt = st_r;
      if (tck_rise)
      begin
         // Controller advance on mode select
         st_nxt.fsm = sbt_next_state(st_r.fsm, pins.tms);
         case (st_r.fsm)
            ST_RESET:
            begin
               st_nxt.ir = INS_READ_ID;
            end
            ST_CAP_IR:
            begin
               st_nxt.ir_sh = {st_r.ir[IR_LEN-1],
                               IR_CAPTURE_PAT};
            end
            ST_SHIFT_IR:
            begin
               st_nxt.ir_sh = {pins.tdi, st_r.ir_sh[IR_LEN-1:1]};
            end
            ST_UPD_IR:
            begin
               st_nxt.ir = st_r.ir_sh;  // Codes assumed legal
            end
            ST_CAP_DR:
            begin
               if (sel_ring(st_r.ir))
               begin
                  st_nxt.ring = ring_in;
               end
               else if (st_r.ir == INS_READ_ID)
               begin
                  st_nxt.id_sh = ID_VALUE;
               end
               else
               begin
                  st_nxt.byp = 1'b0;
               end
            end
            ST_SHIFT_DR:
            begin
               // Shift the selected register, data enters at MSB
               if (sel_ring(st_r.ir))
               begin
                  st_nxt.ring = {pins.tdi, st_r.ring[RING_LEN-1:1]};
               end
               else if (st_r.ir == INS_READ_ID)
               begin
                  st_nxt.id_sh = {pins.tdi, st_r.id_sh[ID_LEN-1:1]};
               end
               else
               begin
                  st_nxt.byp = pins.tdi;
               end
            end
            default:
            begin
               // Update of data has no preload effect
            end
         endcase
         // Entering reset reloads identity at once
         if (st_nxt.fsm == ST_RESET)
         begin
            st_nxt.ir = INS_READ_ID;
         end
      end
      if (tck_fall)
      begin
         // Output drives only in shift states
         st_nxt.tdo_oe = (st_r.fsm == ST_SHIFT_DR) ||
                         (st_r.fsm == ST_SHIFT_IR);
         if (st_r.fsm == ST_SHIFT_IR)
         begin
            st_nxt.tdo = st_r.ir_sh[0];
         end
         else if (sel_ring(st_r.ir))
         begin
            st_nxt.tdo = st_r.ring[0];
         end
         else if (st_r.ir == INS_READ_ID)
         begin
            st_nxt.tdo = st_r.id_sh[0];
         end
         else
         begin
            st_nxt.tdo = st_r.byp;
         end
      end
      // Outputs forced off for the two isolating codes
      st_nxt.out_off = (st_nxt.ir == INS_EXT_CAPTURE) ||
                       (st_nxt.ir == INS_SAMPLE_Z);
   end

   // State register with power-up values
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_r         <= '0;
         st_r.fsm     <= ST_RESET;
         st_r.ir      <= INS_READ_ID;
         st_r.ir_sh   <= INS_READ_ID;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flops
   assign tdo          = st_r.tdo;
   assign tdo_oe       = st_r.tdo_oe;
   assign sram_out_off = st_r.out_off;
   assign ir_active    = st_r.ir;
   assign tap_state    = st_r.fsm;

   // Rising test clock seen in the instruction capture state
   sequence s_ir_capture;
      tck_rise && st_r.fsm == ST_CAP_IR;
   endsequence

   // Saturating count of consecutive high mode select edges
   localparam logic [2:0] TMS_CNT_MAX = 3'(RESET_TMS_EDGES);

   logic [2:0] tms_cnt_r;  // Consecutive high mode edges
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         tms_cnt_r <= '0;
      end
      else if (tck_rise)
      begin
         tms_cnt_r <= pins.tms ? ((tms_cnt_r == TMS_CNT_MAX) ? TMS_CNT_MAX
                                  : tms_cnt_r + 3'h1) : 3'h0;
      end
   end

   a_reset_after_five: assert property (@(posedge clk_sys) disable iff (rst)
      tms_cnt_r == TMS_CNT_MAX |-> st_r.fsm == ST_RESET)
      else $error("controller not reset after five high edges");

   a_reset_loads_id: assert property (@(posedge clk_sys) disable iff (rst)
      tck_rise && st_r.fsm == ST_RESET |=> st_r.ir == INS_READ_ID)
      else $error("reset did not load identity instruction");

   a_ir_capture_pat: assert property (@(posedge clk_sys) disable iff (rst)
      s_ir_capture |=>
      st_r.ir_sh[1:0] == IR_CAPTURE_PAT)
      else $error("instruction capture pattern wrong");

   a_id_capture_val: assert property (@(posedge clk_sys) disable iff (rst)
      tck_rise && st_r.fsm == ST_CAP_DR && st_r.ir == INS_READ_ID |=>
      st_r.id_sh == ID_VALUE && st_r.id_sh[0])
      else $error("identity value not captured");

   a_ring_capture: assert property (@(posedge clk_sys) disable iff (rst)
      tck_rise && st_r.fsm == ST_CAP_DR && sel_ring(st_r.ir) |=>
      st_r.ring == $past(ring_in))
      else $error("ring not captured");

   a_out_off_codes: assert property (@(posedge clk_sys) disable iff (rst)
      ##1 st_r.out_off == ((st_r.ir == INS_EXT_CAPTURE) ||
                          (st_r.ir == INS_SAMPLE_Z)))
      else $error("output isolation does not match instruction");

   a_bypass_path: assert property (@(posedge clk_sys) disable iff (rst)
      tck_rise && st_r.fsm == ST_SHIFT_DR && st_r.ir == INS_BYPASS |=>
      st_r.byp == $past(pins.tdi))
      else $error("bypass did not take serial input");

   a_tdo_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
      !tck_fall |=> $stable(st_r.tdo))
      else $error("serial output changed off the falling edge");

   a_idle_hold: assert property (@(posedge clk_sys) disable iff (rst)
      tck_rise && st_r.fsm == ST_IDLE && !pins.tms |=>
      st_r.fsm == ST_IDLE)
      else $error("idle state not held");

endmodule // sbt_scan_tap

/* include/sbt_pkg.sv */
// Package: constants, states and carriers of the SRAM scan port
package sbt_pkg;

   // Scan register lengths
   localparam int IR_LEN = 3;       // Instruction register
   localparam int ID_LEN = 32;      // Identification register
   localparam int RING_LEN = 75;    // Pin ring register, all widths

   // Instruction codes
   localparam logic [2:0] INS_EXT_CAPTURE = 3'h0; // Capture, outputs off
   localparam logic [2:0] INS_READ_ID     = 3'h1; // Identity read
   localparam logic [2:0] INS_SAMPLE_Z    = 3'h2; // Capture, outputs off
   localparam logic [2:0] INS_SAMPLE      = 3'h4; // Capture only
   localparam logic [2:0] INS_BYPASS      = 3'h7; // One-bit path

   // Instruction capture pattern in the two low bits
   localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

   // Identity field values; arbitrary neutral values except the present bit
   localparam logic [3:0]  ID_REVISION  = 4'h2;   // Arbitrary value
   localparam logic [4:0]  ID_DEPTH_1M  = 5'h0a;  // Arbitrary value
   localparam logic [4:0]  ID_DEPTH_512 = 5'h0b;  // Arbitrary value
   localparam logic [4:0]  ID_WIDTH_18  = 5'h0c;  // Arbitrary value
   localparam logic [4:0]  ID_WIDTH_36  = 5'h0d;  // Arbitrary value
   localparam logic [5:0]  ID_DEVICE    = 6'h00;  // Undefined field
   localparam logic [10:0] ID_MAKER     = 11'h155; // Arbitrary value
   localparam logic        ID_PRESENT   = 1'b1;   // Always one

   // Reset sequence length for the mode select input
   localparam int RESET_TMS_EDGES = 5;

   // Port controller states
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
      ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
      ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } sbt_state_t;

   // Synchronised pin inputs
   typedef struct packed {
      logic tck;   // Test clock level
      logic tms;   // Mode select level
      logic tdi;   // Serial data level
   } sbt_pins_t;

   // Next controller state from mode select
   function automatic sbt_state_t sbt_next_state(sbt_state_t s, logic m);
      case (s)
         ST_RESET:    return m ? ST_RESET    : ST_IDLE;
         ST_IDLE:     return m ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_DR:   return m ? ST_SEL_IR   : ST_CAP_DR;
         ST_CAP_DR:   return m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: return m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: return m ? ST_UPD_DR   : ST_PAUSE_DR;
         ST_PAUSE_DR: return m ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: return m ? ST_UPD_DR   : ST_SHIFT_DR;
         ST_UPD_DR:   return m ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_IR:   return m ? ST_RESET    : ST_CAP_IR;
         ST_CAP_IR:   return m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: return m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: return m ? ST_UPD_IR   : ST_PAUSE_IR;
         ST_PAUSE_IR: return m ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: return m ? ST_UPD_IR   : ST_SHIFT_IR;
         default:     return m ? ST_SEL_DR   : ST_IDLE;
      endcase
   endfunction

endpackage

/* verification/sbt_ctl_model.sv */
// Board test controller model driving the scan port pins
`timescale 1ns/1ps
module sbt_ctl_model
(
   input  wire logic clk_sys,
   input  wire logic tdo,
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   // Pin levels at time zero
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // One test clock period, low phase first; tdo is taken before the rise
   task automatic step(input logic m, input logic d, output logic q);
      @(posedge clk_sys);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (6) @(posedge clk_sys);
      #1 q = tdo;
      @(posedge clk_sys);
      tck <= 1'b1;
      repeat (5) @(posedge clk_sys);
   endtask

   // Mode select high on five rising edges, idle data toggles
   task automatic reset5();
      logic q;
      repeat (5) step(1'b1, ~tdi, q);
   endtask

   // Whole scan from idle back to idle; callers send defined codes only
   task automatic scan(input logic ir, input int n,
                       input logic [74:0] din, output logic [74:0] dout);
      logic q;
      dout = '0;
      step(1'b1, ~tdi, q);
      if (ir)
         step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
      step(1'b0, ~tdi, q);
      // Shift least significant bit first, leave on the last bit
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
   endtask
endmodule // sbt_ctl_model

/* verification/testbench.sv */
// Self-checking bench of the SRAM scan port
`timescale 1ns/1ps
module testbench;
   import sbt_pkg::*;
   logic          clk_sys;          // System clock
   logic          rst;              // Reset
   logic [74:0]   ring_in;          // Pin ring levels
   logic          tck;              // Test clock pin
   logic          tms;              // Mode select pin
   logic          tdi;              // Serial input pin
   logic          tdo;              // Serial output pin
   logic          tdo_oe;           // Serial output enable
   logic          sram_out_off;     // Outputs forced off
   logic [2:0]    ir_active;        // Active instruction
   sbt_state_t    tap_state;        // Controller state
   int            bad_count;        // Mismatches
   int            samples_checked;  // Comparisons
   int            cycles;           // Timeout counter
   logic [9:0]    exp_q[$];         // Expected results
   logic [9:0]    got_q[$];         // Observed results
   logic [9:0]    e_w;              // Oldest expected note
   logic [9:0]    g_w;              // Oldest observed note

   // Clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   sbt_scan_tap i_dut (.clk_sys(clk_sys), .rst(rst), .tck(tck),
      .tms(tms), .tdi(tdi), .ring_in(ring_in), .tdo(tdo),
      .tdo_oe(tdo_oe), .sram_out_off(sram_out_off),
      .ir_active(ir_active), .tap_state(tap_state));
   sbt_ctl_model i_ctl (.clk_sys(clk_sys), .tdo(tdo), .tck(tck),
      .tms(tms), .tdi(tdi));

   // Verdict and end of run
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Serial bit compare
   task automatic cmp_bit(input logic e, input logic g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %0t serial bit %b want %b", $time, g, e);
      end
   endtask

   // Status compare
   task automatic cmp_stat(input logic [8:0] e, input logic [8:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %0t status %h want %h", $time, g, e);
      end
   endtask

   // Note expected and observed status
   task automatic expect_stat(input logic off, input logic [2:0] ir,
                              input sbt_state_t st);
      #1;
      exp_q.push_back({1'b1, 1'b0, off, ir, st});
      got_q.push_back({1'b1, tdo_oe, sram_out_off, ir_active, tap_state});
   endtask

   // Note expected and observed serial bits
   task automatic expect_bits(input int n, input logic [74:0] e,
                              input logic [74:0] g);
      for (int i = 0; i < n; i++)
      begin
         exp_q.push_back({9'h000, e[i]});
         got_q.push_back({9'h000, g[i]});
      end
   endtask

   // Watcher pairs each result with the oldest note; timeout
   always @(posedge clk_sys)
   begin
      cycles++;
      while (got_q.size() > 0 && exp_q.size() > 0)
      begin
         e_w = exp_q.pop_front();
         g_w = got_q.pop_front();
         if (g_w[9])
            cmp_stat(e_w[8:0], g_w[8:0]);
         else
            cmp_bit(e_w[0], g_w[0]);
      end
      if (cycles == 40000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   // Main sequence
   initial
   begin
      logic [2:0]  codes[5];
      logic [2:0]  c;
      logic        prev;
      logic [95:0] rnd;
      logic [74:0] dout;
      logic [74:0] din;
      logic [74:0] ex;
      logic        q;
      int          len;
      codes = '{INS_SAMPLE, INS_READ_ID, INS_BYPASS, INS_SAMPLE_Z,
                INS_EXT_CAPTURE};
      bad_count = 0;
      samples_checked = 0;
      cycles = 0;
      rst = 1'b1;
      ring_in = '0;
      void'($urandom(32'h0a22));
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      expect_stat(1'b0, INS_READ_ID, ST_RESET);
      i_ctl.step(1'b0, 1'b1, q);
      prev = INS_READ_ID[2];
      foreach (codes[k])
      begin
         c = codes[k];
         rnd = {$urandom(), $urandom(), $urandom()};
         @(posedge clk_sys);
         ring_in <= rnd[74:0];
         i_ctl.scan(1'b1, 3, {72'h0, c}, dout);
         expect_bits(3, {72'h0, prev, IR_CAPTURE_PAT}, dout);
         prev = c[2];
         expect_stat(c == INS_EXT_CAPTURE || c == INS_SAMPLE_Z, c,
                     ST_IDLE);
         rnd = {$urandom(), $urandom(), $urandom()};
         din = rnd[74:0];
         len = (c == INS_READ_ID) ? 32 : (c == INS_BYPASS) ? 8 : 75;
         ex = (c == INS_READ_ID) ? {43'h0, ID_REVISION, ID_DEPTH_1M,
              ID_WIDTH_18, ID_DEVICE, ID_MAKER, ID_PRESENT} :
              (c == INS_BYPASS) ? {din[73:0], 1'b0} : ring_in;
         i_ctl.scan(1'b0, len, din, dout);
         expect_bits(len, ex, dout);
      end
      // Abort in mid instruction shift
      i_ctl.step(1'b1, 1'b0, q);
      i_ctl.step(1'b1, 1'b1, q);
      i_ctl.step(1'b0, 1'b0, q);
      i_ctl.step(1'b0, 1'b1, q);
      i_ctl.reset5();
      expect_stat(1'b0, INS_READ_ID, ST_RESET);
      repeat (2) @(posedge clk_sys);
      print_verdict();
   end
endmodule // testbench
